// ==== src/sp_map.vh ====
// Register map, field positions, reset values and timing for the serial port
// Assumes a 32-bit AXI4-Lite slave and one 25 MHz clock
`ifndef SP_MAP_VH
`define SP_MAP_VH
`define SP_OFF_CTRL    8'h00
`define SP_OFF_BUF     8'h04
`define SP_OFF_RATE    8'h08
`define SP_OFF_RELOAD  8'h0C
`define SP_F_RXF       0
`define SP_F_TXF       1
`define SP_F_RB8       2
`define SP_F_REN       4
`define SP_F_AME       5
`define SP_F_MODE_LO   6
`define SP_F_MODE_HI   7
`define SP_F_DOUBLE    0
`define SP_F_T1MODE    4
`define SP_CTRL_RST    8'h00
`define SP_T1_8BIT     4'b0010
`define SP_T1_16BIT    4'b0001
`define SP_RX_INIT0    8'hFE
`define SP_RX_INIT1    9'h1FF
`define SP_OSC_DIV2    1
`define SP_FIX_DIV     16
`endif

// ==== src/sp_serial_port.v ====
// Serial port: shift mode and async frames, timer 1 rate generator, AXI regs
// Assumes one 25 MHz clock, the oscillator; pins arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
`include "sp_map.vh"
module sp_serial_port
(
  // Clock, reset and enable
  input  wire        clock,
  input  wire        resetn,
  input  wire        clock_en,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Data pin, two-way, and clock / transmit pin
  input  wire        port_pin_data_in,
  output reg         port_pin_data_out,
  output reg         port_pin_data_oe,
  output reg         port_pin_clock
);
  localparam OK = 2'b00;
  localparam SLVERR = 2'b10;
  // Registers
  reg [7:0]  ctrl_reg;     // serial_control_reg
  reg [7:0]  rate_reg;     // double bit and timer mode nibble
  reg [15:0] reload_reg;   // reload high/low
  reg [7:0]  buf_rx_reg;   // serial_buffer read side
  reg [15:0] t1_reg;
  reg        t1_ovf_reg;
  reg        dbl_tick_reg;
  reg [3:0]  tx_div_reg;
  reg [3:0]  rx_div_reg;
  reg        rin_s1_reg;
  reg        rin_reg;
  reg        rin_d_reg;
  // Shift engine
  reg [9:0]  tx_sr_reg;
  reg        tx_req_reg;
  reg        send_reg;
  reg        data_en_reg;
  reg        sclk_reg;
  reg [8:0]  rx_sr_reg;
  reg        rx_act_reg;
  reg        rx_arm_reg;
  reg [2:0]  vote_reg;
  reg        wr_buf_reg;
  reg [7:0]  wr_data_reg;
  wire [1:0] mode = {ctrl_reg[`SP_F_MODE_LO],
                     ctrl_reg[`SP_F_MODE_HI]};
  wire       dbl  = rate_reg[`SP_F_DOUBLE];
  wire [3:0] t1m  = rate_reg[7:4];
  wire       is_shift = (mode == 2'b00);

  // Bus handshake terms; write taken when address and data both present
  wire aw_ok = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire ar_ok = s_axi_arvalid & ~s_axi_rvalid;
  wire wr_ctrl = aw_ok && s_axi_awaddr == `SP_OFF_CTRL && s_axi_wstrb[0];
  wire wr_buf  = aw_ok && s_axi_awaddr == `SP_OFF_BUF && s_axi_wstrb[0];

  // Timer 1 as reload counter; 8-bit counts low byte, else 16 bits
  wire t1_8 = (t1m == `SP_T1_8BIT);
  wire t1_wrap = t1_8 ? (t1_reg[7:0] == 8'hFF) : (t1_reg == 16'hFFFF);
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      t1_reg     <= 16'h0000;
      t1_ovf_reg <= 1'b0;
    end
    else if (clock_en)
    begin
      t1_ovf_reg <= t1_wrap;
      if (t1_wrap)
        // Upper byte follows reload so a switch to 16 bits does not stall
        t1_reg <= t1_8 ? {reload_reg[15:8], reload_reg[15:8]} : reload_reg;
      else
        t1_reg <= t1_reg + 16'h0001;
    end
  end

  // Baud tick at 16x bit rate: fixed mode uses osc, halved unless double
  wire src_tick = (mode[1] & ~mode[0]) ? 1'b1 : t1_ovf_reg;
  wire tick16 = src_tick & (dbl | dbl_tick_reg);
  always @(posedge clock)
  begin
    if (!resetn)
      dbl_tick_reg <= 1'b0;
    else if (clock_en)
    begin
      if (src_tick)
        dbl_tick_reg <= ~dbl_tick_reg;
    end
  end
  wire tx_roll = tick16 && tx_div_reg == 4'hF;
  wire rx_roll = tick16 && rx_div_reg == 4'hF;

  // Pin synchroniser, then edge detect on the second stage only
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      rin_s1_reg <= 1'b1;
      rin_reg    <= 1'b1;
      rin_d_reg  <= 1'b1;
    end
    else if (clock_en)
    begin
      rin_s1_reg <= port_pin_data_in;
      rin_reg    <= rin_s1_reg;
      if (tick16)
        rin_d_reg <= rin_reg;
    end
  end
  wire fall = tick16 & rin_d_reg & ~rin_reg;
  wire maj = (vote_reg[0] & vote_reg[1]) | (vote_reg[1] & vote_reg[2]) |
             (vote_reg[0] & vote_reg[2]);

  // Receive and transmit flag events computed once; hardware set wins over clear
  wire sh_rx_done = is_shift & rx_act_reg & sclk_reg & ~rx_sr_reg[7];
  wire as_rx_done = ~is_shift & rx_act_reg & rx_roll & ~rx_sr_reg[8]
                    & (rx_div_reg == 4'hF);
  wire as_accept = ~ctrl_reg[`SP_F_RXF] &
                   (~ctrl_reg[`SP_F_AME] | maj);
  wire sh_tx_done = is_shift & send_reg & sclk_reg & (tx_sr_reg[9:1] == 9'h001);
  wire as_tx_done = ~is_shift & data_en_reg & tx_roll &
                    (tx_sr_reg[9:1] == 9'h001);

  // Serial engine, shift and async
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      tx_sr_reg   <= 10'h000;
      tx_req_reg  <= 1'b0;
      send_reg    <= 1'b0;
      data_en_reg <= 1'b0;
      sclk_reg    <= 1'b1;
      rx_sr_reg   <= 9'h1FF;
      rx_act_reg  <= 1'b0;
      rx_arm_reg  <= 1'b0;
      vote_reg    <= 3'b111;
      tx_div_reg  <= 4'h0;
      rx_div_reg  <= 4'h0;
      wr_buf_reg  <= 1'b0;
      wr_data_reg <= 8'h00;
      buf_rx_reg  <= 8'h00;
      ctrl_reg    <= `SP_CTRL_RST;
    end
    else if (clock_en)
    begin
      wr_buf_reg <= wr_buf;
      if (wr_buf)
        wr_data_reg <= s_axi_wdata[7:0];
      if (tick16)
        tx_div_reg <= tx_div_reg + 4'h1;
      if (fall & ~rx_act_reg & ~is_shift)
        rx_div_reg <= 4'h0;
      else if (tick16)
        rx_div_reg <= rx_div_reg + 4'h1;
      // Software control write; hardware flag sets below override
      if (wr_ctrl)
        ctrl_reg <= s_axi_wdata[7:0];
      if (is_shift)
      begin
        // Shift clock toggles every cycle: osc/2
        if (send_reg | rx_act_reg)
          sclk_reg <= ~sclk_reg;
        else
          sclk_reg <= 1'b1;
        if (wr_buf_reg & ~send_reg)
        begin
          tx_sr_reg <= {1'b0, 1'b1, wr_data_reg};
          send_reg  <= 1'b1;
          // Start low so bit 0 also gets a rising clock
          sclk_reg  <= 1'b0;
        end
        else if (send_reg & sclk_reg)
        begin
          tx_sr_reg <= {1'b0, tx_sr_reg[9:1]};
          if (sh_tx_done)
          begin
            send_reg <= 1'b0;
            ctrl_reg[`SP_F_TXF] <= 1'b1;
          end
        end
        // Receive start and shifting
        if (!rx_act_reg && !rx_arm_reg && ctrl_reg[`SP_F_REN] &&
            !ctrl_reg[`SP_F_RXF] && !send_reg)
        begin
          rx_sr_reg  <= {1'b1, `SP_RX_INIT0};
          rx_arm_reg <= 1'b1;
        end
        else if (rx_arm_reg)
        begin
          rx_arm_reg <= 1'b0;
          rx_act_reg <= 1'b1;
        end
        else if (rx_act_reg & ~sclk_reg)
          vote_reg[0] <= rin_reg;
        else if (rx_act_reg & sclk_reg)
        begin
          rx_sr_reg <= {rx_sr_reg[7:0], vote_reg[0]};
          if (sh_rx_done)
          begin
            rx_act_reg <= 1'b0;
            // First bit in is the LSB
            buf_rx_reg <= {vote_reg[0], rx_sr_reg[0], rx_sr_reg[1],
                           rx_sr_reg[2], rx_sr_reg[3], rx_sr_reg[4],
                           rx_sr_reg[5], rx_sr_reg[6]};
            ctrl_reg[`SP_F_RXF] <= 1'b1;
          end
        end
      end
      else
      begin
        sclk_reg <= 1'b1;
        // Async transmit
        if (wr_buf_reg & ~send_reg)
        begin
          tx_sr_reg  <= {1'b0, 1'b1, wr_data_reg};
          tx_req_reg <= 1'b1;
        end
        if (tx_roll)
        begin
          if (tx_req_reg & ~send_reg)
          begin
            send_reg   <= 1'b1;
            tx_req_reg <= 1'b0;
          end
          else if (send_reg & ~data_en_reg)
            data_en_reg <= 1'b1;
          else if (data_en_reg)
          begin
            tx_sr_reg <= {1'b0, tx_sr_reg[9:1]};
            if (as_tx_done)
            begin
              send_reg    <= 1'b0;
              data_en_reg <= 1'b0;
              ctrl_reg[`SP_F_TXF] <= 1'b1;
            end
          end
        end
        // Async receive
        if (fall & ~rx_act_reg & ctrl_reg[`SP_F_REN])
        begin
          rx_act_reg <= 1'b1;
          rx_sr_reg  <= `SP_RX_INIT1;
        end
        else if (rx_act_reg & tick16)
        begin
          if (rx_div_reg >= 4'h6 && rx_div_reg <= 4'h8)
            vote_reg <= {vote_reg[1:0], rin_reg};
          if (rx_div_reg == 4'hF)
          begin
            if (rx_sr_reg == `SP_RX_INIT1 && maj)
              rx_act_reg <= 1'b0;
            else if (as_rx_done)
            begin
              rx_act_reg <= 1'b0;
              if (as_accept)
              begin
                // Shifted in from the right, so reverse for LSB first
                buf_rx_reg <= {rx_sr_reg[0], rx_sr_reg[1], rx_sr_reg[2],
                               rx_sr_reg[3], rx_sr_reg[4], rx_sr_reg[5],
                               rx_sr_reg[6], rx_sr_reg[7]};
                ctrl_reg[`SP_F_RB8] <= maj;
                ctrl_reg[`SP_F_RXF] <= 1'b1;
              end
            end
            else
              rx_sr_reg <= {rx_sr_reg[7:0], maj};
          end
        end
      end
    end
  end

  // Pins: data pin driven in shift send; async idle is one
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      port_pin_data_out <= 1'b1;
      port_pin_data_oe  <= 1'b0;
      port_pin_clock    <= 1'b1;
    end
    else if (clock_en)
    begin
      port_pin_data_oe  <= is_shift & send_reg;
      port_pin_data_out <= is_shift ? tx_sr_reg[0] : 1'b1;
      if (is_shift)
        port_pin_clock <= sclk_reg;
      else if (data_en_reg)
        port_pin_clock <= tx_sr_reg[0];
      else
        port_pin_clock <= ~send_reg;
    end
  end

  // AXI4-Lite slave; one-cycle accept, answer the next cycle
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= OK;
      s_axi_rdata   <= 32'h0000_0000;
      rate_reg      <= 8'h00;
      reload_reg    <= 16'h0000;
    end
    else if (clock_en)
    begin
      s_axi_awready <= aw_ok & ~s_axi_awready;
      s_axi_wready  <= aw_ok & ~s_axi_awready;
      if (aw_ok & ~s_axi_awready)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (s_axi_awaddr > `SP_OFF_RELOAD) ? SLVERR : OK;
        if (s_axi_awaddr == `SP_OFF_RATE && s_axi_wstrb[0])
          rate_reg <= s_axi_wdata[7:0];
        if (s_axi_awaddr == `SP_OFF_RELOAD)
        begin
          if (s_axi_wstrb[0])
            reload_reg[7:0] <= s_axi_wdata[7:0];
          if (s_axi_wstrb[1])
            reload_reg[15:8] <= s_axi_wdata[15:8];
        end
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= ar_ok & ~s_axi_arready;
      if (ar_ok & ~s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= OK;
        case (s_axi_araddr)
          `SP_OFF_CTRL:   s_axi_rdata <= {24'h00_0000, ctrl_reg};
          `SP_OFF_BUF:    s_axi_rdata <= {24'h00_0000, buf_rx_reg};
          `SP_OFF_RATE:   s_axi_rdata <= {24'h00_0000, rate_reg};
          `SP_OFF_RELOAD: s_axi_rdata <= {16'h0000, reload_reg};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // sp_serial_port
`default_nettype wire

// ==== test/sp_serial_port_asserts.sv ====
// Checker for the serial port register bus and shift-mode pins
// Assumes it is bound onto sp_serial_port, one clock domain
`timescale 1ns/1ps
`default_nettype none
module sp_serial_port_asserts
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        clock_en,
  // Register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pins
  input wire logic        port_pin_data_out,
  input wire logic        port_pin_data_oe,
  input wire logic        port_pin_clock
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Write taken: both halves offered, no answer pending
  sequence s_wtake;
    clock_en && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  // Read taken: address offered, no answer pending
  sequence s_rtake;
    clock_en && s_axi_arvalid && !s_axi_rvalid;
  endsequence

  a_reset_idle: assert property ($rose(resetn) |-> port_pin_clock
    && !port_pin_data_oe && !s_axi_bvalid && !s_axi_rvalid)
    else $error("pins or bus not idle after reset");
  a_write_answer: assert property (s_wtake |=> s_axi_bvalid
    && s_axi_awready && s_axi_wready)
    else $error("write not answered next cycle");
  a_read_answer: assert property (s_rtake |=> s_axi_rvalid
    && s_axi_arready)
    else $error("read not answered next cycle");
  a_write_error: assert property (s_wtake ##0 (s_axi_awaddr > 8'h0C)
    |=> s_axi_bresp == 2'b10)
    else $error("unmapped write not refused");
  a_read_error: assert property (s_rtake ##0 (s_axi_araddr > 8'h0C)
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid)
    else $error("write answer dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed");
  a_ready_pulse: assert property (clock_en && s_axi_awready
    |=> !s_axi_awready)
    else $error("address ready longer than a cycle");
  a_shift_fall: assert property (port_pin_data_oe
    && $past(port_pin_data_oe) && $changed(port_pin_data_out)
    |-> !port_pin_clock)
    else $error("shift data moved off falling clock");
endmodule // sp_serial_port_asserts
`default_nettype wire

// ==== test/sp_peer.sv ====
// Peer on the pins: async sender and receiver, external shift register
// Assumes the bench clock; one bit lasts BIT clocks in async modes
`timescale 1ns/1ps
`default_nettype none
module sp_peer
#(
  parameter int BIT = 16
)
(
  // Clock and mode
  input  wire logic clock,
  input  wire logic shift_mode,
  // Wire levels
  input  wire logic line_clock,
  input  wire logic data_line,
  input  wire logic data_oe,
  output var  logic drive
);
  logic [7:0] got;
  logic       got_stop;
  int         frames = 0;
  int         shifts = 0;
  initial drive = 1'b1;  // Line idles high

  // Shift register takes the data line on each rising shift clock
  always @(posedge line_clock)
    if (shift_mode && data_oe)
    begin
      got = {data_line, got[7:1]};
      shifts++;
    end

  // Async receive, sampling mid-bit; a skewed rate garbles the byte
  always @(negedge line_clock)
    if (!shift_mode)
    begin
      repeat (BIT / 2) @(posedge clock);
      repeat (8)
      begin
        repeat (BIT) @(posedge clock);
        got = {line_clock, got[7:1]};
      end
      repeat (BIT) @(posedge clock);
      got_stop = line_clock;
      frames++;
    end

  // One frame; a stop of 0 is sent only when a scenario asks for it
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    repeat (10)
    begin
      drive <= f[0];
      f = f >> 1;
      repeat (BIT) @(posedge clock);
    end
    drive <= 1'b1;
  endtask

  // Short low glitch, too brief to be a start bit
  task automatic pulse(input int n);
    drive <= 1'b0;
    repeat (n) @(posedge clock);
    drive <= 1'b1;
  endtask
endmodule // sp_peer
`default_nettype wire

// ==== test/sp_serial_port_tb.sv ====
// Bench for the serial port: registers, shift send, async both ways
// Assumes the peer model and checker files compiled before this one
`timescale 1ns/1ps
`default_nettype none
`include "sp_map.vh"
module sp_serial_port_tb;
  logic        clock, resetn, clock_en, shift_mode, peer_drive;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        port_pin_data_out, port_pin_data_oe, port_pin_clock;
  int          errors, comparisons, cycles, t_first, t_last;
  // Data wire: device drives only while sending in shift mode
  wire logic   port_pin_data_in = port_pin_data_oe ?
                                  port_pin_data_out : peer_drive;

  sp_serial_port i_sp_serial_port (.clock, .resetn, .clock_en,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .port_pin_data_in, .port_pin_data_out,
    .port_pin_data_oe, .port_pin_clock);
  sp_peer #(.BIT(16)) i_sp_peer (.clock, .shift_mode,
    .line_clock(port_pin_clock), .data_line(port_pin_data_in),
    .data_oe(port_pin_data_oe), .drive(peer_drive));

  always #20 clock = ~clock;
  // Hang guard, far above the few thousand cycles needed
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      conclude();
    end
  end
  // Shift clock spacing while the device sends
  always @(posedge port_pin_clock)
    if (port_pin_data_oe)
    begin
      if (t_first == 0) t_first = cycles;
      t_last = cycles;
    end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
      rs = s_axi_bresp;
    end while (s_axi_bvalid !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
      rv = s_axi_rdata;
      rs = s_axi_rresp;
    end while (s_axi_rvalid !== 1'b1);
  endtask

  // Poll a control flag; the hang guard bounds the wait
  task automatic waitf(input int b);
    do rd(`SP_OFF_CTRL); while (rv[b] !== 1'b1);
  endtask

  task automatic t_regs();
    rd(`SP_OFF_CTRL);
    chk(rv, 32'h0);
    rd(`SP_OFF_RATE);
    chk(rv, 32'h0);
    rd(8'h10);
    chk({rs, rv}, {2'b10, 32'h0});
    wr(8'h14, 32'h1);
    chk(rs, 2'b10);
  endtask

  task automatic t_shift_tx();
    wr(`SP_OFF_CTRL, 32'h0);
    wr(`SP_OFF_BUF, 32'hA5);
    waitf(`SP_F_TXF);
    chk(i_sp_peer.got, 8'hA5);
    chk(i_sp_peer.shifts, 8);
    chk(t_last - t_first, 14);
  endtask

  // Every async mode and both timer reloads give 16 clocks a bit
  task automatic t_async_tx();
    logic [7:0] md [4] = '{8'h80, 8'h40, 8'hC0, 8'h80};
    logic [7:0] rt [4] = '{8'h21, 8'h21, 8'h21, 8'h11};
    int n;
    shift_mode <= 1'b0;
    wr(`SP_OFF_RELOAD, 32'hFFFF);
    for (int i = 0; i < 4; i++)
    begin
      n = i_sp_peer.frames;
      wr(`SP_OFF_RATE, rt[i]);
      wr(`SP_OFF_CTRL, md[i]);
      wr(`SP_OFF_BUF, 8'h3C + i);
      waitf(`SP_F_TXF);
      while (i_sp_peer.frames == n) @(posedge clock);
      chk(i_sp_peer.got, 8'h3C + i);
      if (md[i] == 8'h80) chk(i_sp_peer.got_stop, 1'b1);
    end
  endtask

  task automatic t_async_rx();
    wr(`SP_OFF_CTRL, 32'h90);
    i_sp_peer.send(8'hC3, 1'b1);
    waitf(`SP_F_RXF);
    chk(rv[`SP_F_RB8], 1'b1);
    i_sp_peer.send(8'h55, 1'b1);
    rd(`SP_OFF_BUF);
    chk(rv, 32'hC3);
    wr(`SP_OFF_CTRL, 32'h90);
    i_sp_peer.pulse(4);
    repeat (40) @(posedge clock);
    i_sp_peer.send(8'h96, 1'b1);
    waitf(`SP_F_RXF);
    rd(`SP_OFF_BUF);
    chk(rv, 32'h96);
    wr(`SP_OFF_CTRL, 32'hB0);
    i_sp_peer.send(8'h69, 1'b0);
    repeat (40) @(posedge clock);
    rd(`SP_OFF_CTRL);
    chk(rv[`SP_F_RXF], 1'b0);
  endtask

  task automatic conclude();
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    {clock, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {errors, comparisons, cycles, t_first, t_last} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    clock_en = 1'b1;
    shift_mode = 1'b1;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    t_regs();
    t_shift_tx();
    t_async_tx();
    t_async_rx();
    conclude();
  end
endmodule // sp_serial_port_tb

bind sp_serial_port sp_serial_port_asserts i_sp_serial_port_asserts (
  .clock, .resetn, .clock_en, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .port_pin_data_out, .port_pin_data_oe,
  .port_pin_clock);
`default_nettype wire
